// *** hw/ets_defines.svh ***
// constants for the embedded trigger sampler: register map, field positions, sizes
// assumes a 32-bit apb slave with byte addresses and word-aligned registers
`ifndef ETS_DEFINES_SVH
`define ETS_DEFINES_SVH

// build sizes
`define ETS_WATCH_W     8
`define ETS_BP_W        4
`define ETS_DEPTH       16
`define ETS_IDX_W       4
`define ETS_NUM_COND    4
`define ETS_NUM_STATES  4
`define ETS_ST_W        2
`define ETS_CNT_W       8
`define ETS_CNT_BUILT   1
`define ETS_COMPRESS    0
`define ETS_TBL_AW      7
`define ETS_TBL_DEPTH   128
`define ETS_ENTRY_W     13

// register byte offsets
`define ETS_OFS_CTRL     12'h000
`define ETS_OFS_STATUS   12'h004
`define ETS_OFS_CNT_INIT 12'h008
`define ETS_OFS_TBL_ADDR 12'h00C
`define ETS_OFS_TBL_DATA 12'h010
`define ETS_OFS_BUF_IDX  12'h014
`define ETS_OFS_BUF_DATA 12'h018
`define ETS_OFS_CAPS     12'h01C
`define ETS_OFS_COND0    12'h020
`define ETS_OFS_COND_END 12'h030

// control fields
`define ETS_CTRL_ARM     0
`define ETS_CTRL_STOP    1
`define ETS_CTRL_QUAL    2
`define ETS_CTRL_ALWAYS  3
`define ETS_CTRL_FALL    4
`define ETS_CTRL_MODE_LO 5
`define ETS_CTRL_MODE_HI 6

// condition word fields
`define ETS_COND_VAL_LO  0
`define ETS_COND_MSK_LO  8
`define ETS_COND_BP_LO   16

// reset values
`define ETS_CTRL_RST     32'h0000_0000
`define ETS_COND_RST     32'h0000_0000

`endif

// *** hw/ets_pkg.sv ***
// types shared by the embedded trigger sampler modules
// assumes ets_defines.svh is on the include path
`include "ets_defines.svh"

package ets_pkg;

    // trigger flavour chosen by software
    typedef enum logic [1:0] {
        MODE_SIMPLE,
        MODE_COUNTER,
        MODE_STATE_MACHINE,
        MODE_SPARE
    } trig_mode_e;

    // one word of the trigger lookup table
    typedef struct packed {
        logic [`ETS_ST_W-1:0]  nstate;
        logic                  trigger;
        logic                  cnten;
        logic                  cntld;
        logic [`ETS_CNT_W-1:0] cntval;
    } tbl_entry_s;

    // one captured sample
    typedef struct packed {
        logic [`ETS_BP_W-1:0]    bp;
        logic [`ETS_WATCH_W-1:0] watch;
    } sample_s;

endpackage

// *** hw/ets_trigger_table.sv ***
// lookup table of the trigger state machine, flip-flop storage
// assumes writes from the register side and a combinational lookup on the same clock
module ets_trigger_table
    import ets_pkg::*;
(
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_wr_en,
    input  wire logic [`ETS_TBL_AW-1:0]   i_wr_idx,
    input  wire tbl_entry_s               i_wr_data,
    input  wire logic [`ETS_TBL_AW-1:0]   i_lookup_idx,
    output tbl_entry_s                    o_entry
);

    tbl_entry_s table_reg [`ETS_TBL_DEPTH];

    // one storage word per table entry
    genvar g;
    generate
        for (g = 0; g < `ETS_TBL_DEPTH; g++) begin : g_entry
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    table_reg[g] <= '0;
                end else if (i_wr_en && (i_wr_idx == `ETS_TBL_AW'(g))) begin
                    table_reg[g] <= i_wr_data;
                end
            end
        end
    endgenerate

    // lookup addressed by conditions, zero flag and state
    assign o_entry = table_reg[i_lookup_idx];

endmodule // ets_trigger_table

// *** hw/ets_sample_buffer.sv ***
// capture buffer of the sampler, flip-flop storage with one write and one read port
// assumes the write index comes from the capture control on the same clock
module ets_sample_buffer
    import ets_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_wr_en,
    input  wire logic [`ETS_IDX_W-1:0]  i_wr_idx,
    input  wire sample_s                i_wr_data,
    input  wire logic [`ETS_IDX_W-1:0]  i_rd_idx,
    output sample_s                     o_rd_data
);

    sample_s buf_reg [`ETS_DEPTH];

    // capture write into the indexed entry
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            buf_reg[i_wr_idx] <= i_wr_data;
        end
    end

    // read for the register side
    assign o_rd_data = buf_reg[i_rd_idx];

endmodule // ets_sample_buffer

// *** hw/embedded_trigger_sampler.sv ***
// embedded trigger sampler: signal capture with simple, counter and state-machine triggering
// assumes observed signals and the sample clock are asynchronous pins; apb on i_clk
module embedded_trigger_sampler
    import ets_pkg::*;
(
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_sample_clk,
    input  wire logic [`ETS_WATCH_W-1:0]  i_watch,
    input  wire logic [`ETS_BP_W-1:0]     i_bp,
    input  wire logic                     i_psel,
    input  wire logic                     i_penable,
    input  wire logic                     i_pwrite,
    input  wire logic [11:0]              i_paddr,
    input  wire logic [31:0]              i_pwdata,
    output logic      [31:0]              o_prdata,
    output logic                          o_pready,
    output logic                          o_pslverr
);

    typedef enum logic [1:0] {
        CAP_IDLE,
        CAP_ARMED,
        CAP_FILL,
        CAP_DONE
    } cap_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [2:0]                 sclk_sync_reg;
    sample_s                    in_meta_reg;
    sample_s                    in_sync_reg;
    logic                       sample_evt;

    logic [31:0]                ctrl_reg;
    logic [`ETS_CNT_W-1:0]      cnt_init_reg;
    logic [`ETS_TBL_AW-1:0]     tbl_addr_reg;
    logic [`ETS_IDX_W-1:0]      buf_idx_reg;
    logic [31:0]                cond_reg [`ETS_NUM_COND];

    logic                       ack_reg;
    logic [31:0]                prdata_reg;
    logic                       slverr_reg;
    logic                       setup;
    logic                       wr_fire;
    logic                       arm_pulse;
    logic                       stop_pulse;
    logic                       tbl_wr;
    logic [31:0]                rd_next;
    logic                       rd_hit;

    trig_mode_e                 mode;
    logic [`ETS_NUM_COND-1:0]   cond_hit;
    logic                       cnt_zero;
    logic [`ETS_CNT_W-1:0]      cnt_reg;
    logic [`ETS_ST_W-1:0]       tstate_reg;
    tbl_entry_s                 entry;
    logic                       trig;
    logic                       trig_prev_reg;
    logic                       trig_rise;
    logic                       running;

    cap_state_e                 cap_reg;
    logic [`ETS_IDX_W-1:0]      wptr_reg;
    logic                       buf_wr;
    logic [`ETS_IDX_W-1:0]      buf_wr_idx;
    sample_s                    buf_rd;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // two flops on every observed pin, third flop only for edge compare
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sclk_sync_reg <= 3'h0;
            in_meta_reg   <= '0;
            in_sync_reg   <= '0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], i_sample_clk};
            in_meta_reg   <= '{bp: i_bp, watch: i_watch};
            in_sync_reg   <= in_meta_reg;
        end
    end

    assign sample_evt = ctrl_reg[`ETS_CTRL_FALL] ? (sclk_sync_reg[2] & ~sclk_sync_reg[1])
                                                 : (sclk_sync_reg[1] & ~sclk_sync_reg[2]);

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one setup cycle, one access cycle

    assign setup      = i_psel & ~i_penable;
    assign wr_fire    = i_psel & i_penable & ack_reg & i_pwrite;
    assign arm_pulse  = wr_fire && (i_paddr == `ETS_OFS_CTRL) && i_pwdata[`ETS_CTRL_ARM];
    assign stop_pulse = wr_fire && (i_paddr == `ETS_OFS_CTRL) && i_pwdata[`ETS_CTRL_STOP];
    assign tbl_wr     = wr_fire && (i_paddr == `ETS_OFS_TBL_DATA);
    assign o_pready   = i_psel & i_penable & ack_reg;
    assign o_prdata   = prdata_reg;
    assign o_pslverr  = slverr_reg & o_pready;

    // read mux, decoded in the setup cycle
    always_comb begin
        rd_next = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (i_paddr)
            `ETS_OFS_CTRL:     rd_next = ctrl_reg & ~32'h0000_0003;
            `ETS_OFS_STATUS:   rd_next = {8'h00, cnt_reg, 5'h00, cnt_zero, tstate_reg,
                                          wptr_reg, 2'h0, cap_reg};
            `ETS_OFS_CNT_INIT: rd_next = {24'h00_0000, cnt_init_reg};
            `ETS_OFS_TBL_ADDR: rd_next = {25'h000_0000, tbl_addr_reg};
            `ETS_OFS_TBL_DATA: rd_next = {19'h0_0000, entry};
            `ETS_OFS_BUF_IDX:  rd_next = {28'h000_0000, buf_idx_reg};
            `ETS_OFS_BUF_DATA: rd_next = {20'h0_0000, buf_rd};
            `ETS_OFS_CAPS:     rd_next = {15'h0000, 1'(`ETS_COMPRESS), 8'(`ETS_CNT_W),
                                          4'(`ETS_NUM_STATES - 1), 4'(`ETS_NUM_COND - 1)};
            default: begin
                if (i_paddr >= `ETS_OFS_COND0 && i_paddr < `ETS_OFS_COND_END && i_paddr[1:0] == 2'h0) begin
                    rd_next = cond_reg[i_paddr[3:2]];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // handshake and read data capture
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ack_reg    <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else if (setup) begin
            ack_reg    <= 1'b1;
            prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_next;
            slverr_reg <= ~rd_hit || (i_pwrite && i_paddr == `ETS_OFS_STATUS);
        end else if (o_pready) begin
            ack_reg    <= 1'b0;
        end
    end

    // writable configuration registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_reg     <= `ETS_CTRL_RST;
            cnt_init_reg <= 8'h00;
            buf_idx_reg  <= 4'h0;
        end else if (wr_fire) begin
            if (i_paddr == `ETS_OFS_CTRL)     ctrl_reg     <= i_pwdata & 32'h0000_007C;
            if (i_paddr == `ETS_OFS_CNT_INIT) cnt_init_reg <= i_pwdata[`ETS_CNT_W-1:0];
            if (i_paddr == `ETS_OFS_BUF_IDX)  buf_idx_reg  <= i_pwdata[`ETS_IDX_W-1:0];
        end
    end

    // table address, steps after each table data write
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tbl_addr_reg <= 7'h00;
        end else if (wr_fire && i_paddr == `ETS_OFS_TBL_ADDR) begin
            tbl_addr_reg <= i_pwdata[`ETS_TBL_AW-1:0];
        end else if (tbl_wr) begin
            tbl_addr_reg <= tbl_addr_reg + 7'h01;
        end
    end

    assign mode = trig_mode_e'(ctrl_reg[`ETS_CTRL_MODE_HI:`ETS_CTRL_MODE_LO]);

    ////////////////////////////////////////////////////////////////////////////
    // trigger conditions

    genvar c;
    generate
        // identical wiring, independent programming per condition
        for (c = 0; c < `ETS_NUM_COND; c++) begin : g_cond
            logic [`ETS_WATCH_W-1:0] val;
            logic [`ETS_WATCH_W-1:0] msk;
            logic [`ETS_BP_W-1:0]    bsel;
            assign val  = cond_reg[c][`ETS_COND_VAL_LO +: `ETS_WATCH_W];
            assign msk  = cond_reg[c][`ETS_COND_MSK_LO +: `ETS_WATCH_W];
            assign bsel = cond_reg[c][`ETS_COND_BP_LO +: `ETS_BP_W];

            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    cond_reg[c] <= `ETS_COND_RST;
                end else if (wr_fire && i_paddr == (`ETS_OFS_COND0 + 12'(4 * c))) begin
                    cond_reg[c] <= i_pwdata & 32'h000F_FFFF;
                end
            end

            // all selected breakpoints and masked watch compare
            assign cond_hit[c] = (&(in_sync_reg.bp | ~bsel)) &&
                                 ((in_sync_reg.watch & msk) == (val & msk));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // trigger state machine and counter

    assign running = (cap_reg != CAP_IDLE);
    assign cnt_zero = (cnt_reg == 8'h00);

    // state bits, zero flag, one address bit per condition in state-machine mode, else the table address
    ets_trigger_table u_table (
        .i_clk        (i_clk),
        .i_rst_n      (i_rst_n),
        .i_wr_en      (tbl_wr),
        .i_wr_idx     (tbl_addr_reg),
        .i_wr_data    (tbl_entry_s'(i_pwdata[`ETS_ENTRY_W-1:0])),
        .i_lookup_idx ((mode == MODE_STATE_MACHINE) ? {tstate_reg, cnt_zero, cond_hit} : tbl_addr_reg),
        .o_entry      (entry)
    );

    // state register width covers the state count
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || arm_pulse) begin
            tstate_reg <= 2'h0;
        end else if (sample_evt && running && mode == MODE_STATE_MACHINE) begin
            tstate_reg <= entry.nstate;
        end
    end

    generate
        // counter only when built; its table fields used only then
        if (`ETS_CNT_BUILT != 0) begin : g_counter
            // counter mode counts condition hits down from the initial value
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    cnt_reg <= 8'h00;
                end else if (arm_pulse) begin
                    cnt_reg <= cnt_init_reg;
                end else if (sample_evt && running) begin
                    if (mode == MODE_STATE_MACHINE) begin
                        if (entry.cntld) begin
                            cnt_reg <= entry.cntval;
                        end else if (entry.cnten) begin
                            cnt_reg <= cnt_reg - 8'h01;
                        end
                    end else if (mode == MODE_COUNTER && cond_hit[0] && !cnt_zero) begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
            end
        end else begin : g_no_counter
            assign cnt_reg = 8'h00;
        end
    endgenerate

    // trigger source per mode
    always_comb begin
        unique case (mode)
            MODE_SIMPLE:        trig = cond_hit[0];
            // condition once the count is spent
            MODE_COUNTER:       trig = cond_hit[0] & cnt_zero;
            MODE_STATE_MACHINE: trig = entry.trigger;
            default:            trig = 1'b0;
        endcase
    end

    // previous trigger value at the last sample edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || arm_pulse) begin
            trig_prev_reg <= 1'b0;
        end else if (sample_evt) begin
            trig_prev_reg <= trig;
        end
    end

    assign trig_rise = trig & ~trig_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // capture control

    ets_sample_buffer u_buffer (
        .i_clk     (i_clk),
        .i_wr_en   (buf_wr),
        .i_wr_idx  (buf_wr_idx),
        .i_wr_data (in_sync_reg),
        .i_rd_idx  (buf_idx_reg),
        .o_rd_data (buf_rd)
    );

    // write decision on each sample edge
    always_comb begin
        buf_wr     = 1'b0;
        buf_wr_idx = wptr_reg;
        if (sample_evt) begin
            unique case (cap_reg)
                CAP_ARMED: begin
                    buf_wr     = trig;
                    buf_wr_idx = 4'h0;
                end
                CAP_FILL: begin
                    // in always-armed mode a fresh rising trigger restarts the snapshot
                    if (ctrl_reg[`ETS_CTRL_ALWAYS] && trig_rise) begin
                        buf_wr     = 1'b1;
                        buf_wr_idx = 4'h0;
                    // qualified mode stores only on true condition
                    end else begin
                        buf_wr = ~ctrl_reg[`ETS_CTRL_QUAL] | trig;
                    end
                end
                CAP_DONE: begin
                    buf_wr     = ctrl_reg[`ETS_CTRL_ALWAYS] & trig_rise;
                    buf_wr_idx = 4'h0;
                end
                CAP_IDLE: begin
                    buf_wr = 1'b0;
                end
            endcase
        end
    end

    // capture state and write pointer
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || stop_pulse) begin
            cap_reg  <= CAP_IDLE;
            wptr_reg <= 4'h0;
        end else if (arm_pulse) begin
            cap_reg  <= CAP_ARMED;
            wptr_reg <= 4'h0;
        end else if (buf_wr) begin
            if (buf_wr_idx == 4'hF) begin
                cap_reg  <= CAP_DONE;
                wptr_reg <= 4'h0;
            end else begin
                // keep filling from the next entry after each stored sample short of the last
                cap_reg  <= CAP_FILL;
                wptr_reg <= buf_wr_idx + 4'h1;
            end
        end
    end

endmodule // embedded_trigger_sampler

// *** dv/ets_apb_props.sv ***
// checker for the register port of the trigger sampler
// assumes it sees only the top module's ports, bound in below
module ets_apb_checker (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic acc;
    // a completed transfer
    assign acc = i_psel && i_penable && o_pready;
    ////////////////////////////////////////////////////////////////
    a_ready_no_wait: assert property (i_psel && !i_penable ##1 i_psel && i_penable |-> o_pready) // apb timing
        else $error("ready missing in first access cycle");
    a_ready_in_access: assert property (o_pready |-> i_psel && i_penable) // apb timing
        else $error("ready outside access cycle");
    a_err_with_ready: assert property (o_pslverr |-> o_pready) // apb timing
        else $error("error without ready");
    a_err_unmapped: assert property (acc && i_paddr >= 12'h030 |-> o_pslverr) // apb decode
        else $error("unmapped access not refused");
    a_err_status_wr: assert property (acc && i_pwrite && i_paddr == 12'h004 |-> o_pslverr) // apb decode
        else $error("status write not refused");
    a_no_err_mapped: assert property (acc && i_paddr < 12'h030 && i_paddr[1:0] == 2'h0 &&
        !(i_pwrite && i_paddr == 12'h004) |-> !o_pslverr) // apb decode
        else $error("mapped access refused");
    a_caps_word: assert property (acc && !i_pwrite && i_paddr == 12'h01C |-> o_prdata == 32'h0000_0833)
        else $error("capability word wrong");
    a_ctrl_pulse_bits: assert property (acc && !i_pwrite && i_paddr == 12'h000 |-> o_prdata[1:0] == 2'h0)
        else $error("arm or stop bit reads back");
    a_read_holds: assert property (acc && !i_pwrite ##1 !i_psel |-> $stable(o_prdata)) // apb timing
        else $error("read data changed before next setup");
endmodule // ets_apb_checker

bind embedded_trigger_sampler ets_apb_checker chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr));

// *** dv/ets_signal_source.sv ***
// model of the observed logic: a slow sample clock and the signals it carries
// assumes the system clock is far faster than the sample clock made here
module ets_signal_source (
    input  wire logic       i_clk,
    output logic            o_sample_clk,
    output logic [7:0]      o_watch,
    output logic [3:0]      o_bp
);
    timeunit 1ns;
    timeprecision 1ps;
    // sample clock stands low between pulses
    initial begin
        o_sample_clk = 1'b0;
        o_watch = 8'h00;
        o_bp = 4'h0;
    end
    // one pulse: first value held over the rise, second over the fall
    task automatic ev(input logic [7:0] w1, input logic [3:0] b1, input logic [7:0] w2, input logic [3:0] b2);
        o_watch <= w1;
        o_bp <= b1;
        repeat (3) @(posedge i_clk);
        o_sample_clk <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_watch <= w2;
        o_bp <= b2;
        repeat (3) @(posedge i_clk);
        o_sample_clk <= 1'b0;
        repeat (5) @(posedge i_clk);
    endtask
endmodule // ets_signal_source

// *** dv/embedded_trigger_sampler_bench.sv ***
// self-checking bench of the trigger sampler: apb tasks and capture sequences
// assumes the signal source model drives the observed pins
module embedded_trigger_sampler_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, sclk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  watch;
    logic [3:0]  bp;
    int          mismatches, tests_run, k;
    ets_signal_source src_u (.i_clk(i_clk), .o_sample_clk(sclk), .o_watch(watch), .o_bp(bp));
    embedded_trigger_sampler dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sample_clk(sclk), .i_watch(watch),
        .i_bp(bp), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
    ////////////////////////////////////////////////////////////////
    // one apb transfer: request held until ready is seen high at a rising edge, data taken there
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic bufc(input logic [3:0] i, input logic [31:0] e);
        wr(12'h014, {28'h0, i});
        rdc(12'h018, 32'h0000_0FFF, e);
    endtask
    // set the mode first, then arm with it
    task automatic arm(input logic [31:0] m);
        wr(12'h000, m);
        wr(12'h000, m | 32'h1);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // watchdog well beyond the expected run
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    initial begin
        {i_rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdc(12'h01C, 32'hFFFF_FFFF, 32'h0000_0833);
        rdc(12'h004, 32'hFFFF_FFFF, 32'h0000_0400);
        apb(1'b0, 12'h040, 32'h0);
        wr(12'h004, 32'hFFFF_FFFF);
        $display("test reset done");
        // simple trigger: value match plus breakpoint 0
        wr(12'h020, 32'h0001_FFA5);
        arm(32'h0);
        src_u.ev(8'hA5, 4'h0, 8'hA5, 4'h0);
        src_u.ev(8'h00, 4'h1, 8'h00, 4'h1);
        for (k = 0; k < 16; k++) src_u.ev(k == 0 ? 8'hA5 : 8'(k), k == 0 ? 4'h1 : 4'h2, 8'h00, 4'h0);
        rdc(12'h004, 32'h3, 32'h3);
        bufc(4'h0, 32'h1A5);
        bufc(4'hF, 32'h20F);
        $display("test simple done");
        // falling edge takes the second value of each pulse
        arm(32'h10);
        src_u.ev(8'h00, 4'h0, 8'hA5, 4'h1);
        src_u.ev(8'hA5, 4'h1, 8'h3C, 4'h0);
        rdc(12'h004, 32'h3, 32'h2);
        bufc(4'h0, 32'h1A5);
        bufc(4'h1, 32'h03C);
        wr(12'h000, 32'h2);
        $display("test falling done");
        // qualified: only true events are stored
        wr(12'h020, 32'h0001_F0A0);
        arm(32'h4);
        for (k = 0; k < 16; k++) begin
            src_u.ev(8'hA0 | 8'(k), 4'h1, 8'h00, 4'h0);
            src_u.ev(8'h50 | 8'(k), 4'h1, 8'h00, 4'h0);
        end
        rdc(12'h004, 32'h3, 32'h3);
        bufc(4'h5, 32'h1A5);
        bufc(4'hF, 32'h1AF);
        $display("test qualified done");
        // always armed: a new rising trigger restarts, stop keeps data
        arm(32'h8);
        src_u.ev(8'hA1, 4'h1, 8'h00, 4'h0);
        src_u.ev(8'h52, 4'h1, 8'h00, 4'h0);
        src_u.ev(8'hA3, 4'h1, 8'h00, 4'h0);
        rdc(12'h004, 32'h3, 32'h2);
        bufc(4'h0, 32'h1A3);
        wr(12'h000, 32'h2);
        rdc(12'h004, 32'h3, 32'h0);
        bufc(4'h0, 32'h1A3);
        $display("test always armed done");
        // counter: trigger once the count from 2 has run out
        wr(12'h008, 32'h2);
        arm(32'h20);
        for (k = 1; k < 4; k++) src_u.ev(8'hA0 | 8'(k), 4'h1, 8'h00, 4'h0);
        rdc(12'h004, 32'h00FF_0403, 32'h0000_0402);
        bufc(4'h0, 32'h1A3);
        $display("test counter done");
        // state machine table: load, count down, trigger on zero
        wr(12'h008, 32'h0);
        wr(12'h00C, 32'h1F);
        wr(12'h010, 32'h0B02);
        wr(12'h00C, 32'h2F);
        wr(12'h010, 32'h0A00);
        wr(12'h00C, 32'h3F);
        wr(12'h010, 32'h1400);
        wr(12'h00C, 32'h1F);
        rdc(12'h010, 32'h1FFF, 32'h0B02);
        arm(32'h40);
        src_u.ev(8'hA1, 4'h1, 8'h00, 4'h0);
        rdc(12'h004, 32'h00FF_0303, 32'h0002_0101);
        for (k = 2; k < 5; k++) src_u.ev(8'hA0 | 8'(k), 4'h1, 8'h00, 4'h0);
        rdc(12'h004, 32'h00FF_0703, 32'h0000_0602);
        bufc(4'h0, 32'h1A4);
        $display("test state machine done");
        conclude();
    end
endmodule // embedded_trigger_sampler_bench
